// File: rtl/csf_status_reg.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module csf_status_reg (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RST,
  // Instruction execution from the decoder
  input  wire logic             EXEC,
  input  wire csf_pkg::csf_op_t OP,
  input  wire logic [7:0]       OPND_W,
  input  wire logic [7:0]       OPND_F,
  input  wire logic             DEST_IS_FLAGS,
  // Watchdog time-out event from the watchdog
  input  wire logic             WDT_TIMEOUT,
  // Instruction result towards the file write path
  output logic [7:0]            RESULT,
  output logic                  RESULT_VALID,
  // Direct addressing
  input  wire logic [6:0]       DIRECT_OFS,
  output logic [7:0]            DATA_ADDR,
  // Flag view for the core
  output logic [7:0]            FLAGS,
  // Register port
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic [7:0]            REG_RDATA,
  // Interrupt
  output logic                  IRQ
);

  logic [7:0] alu_result;
  logic       alu_zero;
  logic       alu_nibble;
  logic       alu_carry;
  logic       upd_zero;
  logic       upd_nibble;
  logic       upd_carry;

  logic [2:0] upper_r;
  logic       timeout_r;
  logic       sleep_r;
  logic       zero_r;
  logic       nibble_r;
  logic       carry_r;
  logic [7:0] result_r;
  logic       result_valid_r;
  logic [7:0] rdata_r;
  logic [2:0] irq_status_r;
  logic [2:0] irq_enable_r;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [7:0] flags_view;

  logic       instr_wr_flags;
  logic       bus_wr_flags;
  logic       op_clear;
  logic       op_wdt_clr;
  logic       op_sleep;
  logic       wr_irq_enable;
  logic       wr_irq_clear;

  csf_alu u_alu (
    .op         (OP),
    .opnd_w     (OPND_W),
    .opnd_f     (OPND_F),
    .carry_in   (carry_r),
    .result     (alu_result),
    .zero       (alu_zero),
    .nibble     (alu_nibble),
    .carry      (alu_carry),
    .upd_zero   (upd_zero),
    .upd_nibble (upd_nibble),
    .upd_carry  (upd_carry)
  );

  assign instr_wr_flags = EXEC && DEST_IS_FLAGS
                       && (OP != csf_pkg::OP_NONE)
                       && (OP != csf_pkg::OP_WDT_CLR)
                       && (OP != csf_pkg::OP_SLEEP);
  // An instruction writing the flags in the same cycle takes precedence,
  // since the core sequence must not be disturbed by software.
  assign bus_wr_flags  = REG_WR && (REG_ADDR == csf_pkg::OFS_FLAGS)
                      && !instr_wr_flags;
  assign op_clear      = EXEC && (OP == csf_pkg::OP_CLEAR);
  assign op_wdt_clr    = EXEC && (OP == csf_pkg::OP_WDT_CLR);
  assign op_sleep      = EXEC && (OP == csf_pkg::OP_SLEEP);
  assign wr_irq_enable = REG_WR && (REG_ADDR == csf_pkg::OFS_IRQ_ENABLE);
  assign wr_irq_clear  = REG_WR && (REG_ADDR == csf_pkg::OFS_IRQ_CLEAR);

  // Upper three bits: indirect page, page high and page low.
  always_ff @(posedge CLK) begin
    if (RST) begin
      upper_r <= csf_pkg::FLAGS_RESET[7:5];
    end else if (instr_wr_flags) begin
      upper_r <= alu_result[7:5];
    end else if (bus_wr_flags) begin
      upper_r <= REG_WDATA[7:5];
    end
  end

  // Time-out flag. A time-out in the same cycle as a clear or sleep wins,
  // so that a real watchdog expiry is never hidden from software.
  // no write path
  always_ff @(posedge CLK) begin
    if (RST) begin
      timeout_r <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_TIMEOUT];
    end else if (WDT_TIMEOUT) begin
      timeout_r <= 1'b0;
    end else if (op_wdt_clr || op_sleep) begin
      timeout_r <= 1'b1;
    end
  end

  // Power-down flag.
  always_ff @(posedge CLK) begin
    if (RST) begin
      sleep_r <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_SLEEP];
    end else if (op_sleep) begin
      sleep_r <= 1'b0;
    end else if (op_wdt_clr) begin
      sleep_r <= 1'b1;
    end
  end

  // Zero flag.
  always_ff @(posedge CLK) begin
    if (RST) begin
      zero_r <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_ZERO];
    end else if (EXEC && upd_zero) begin
      zero_r <= alu_zero;
    end else if (instr_wr_flags) begin
      zero_r <= alu_result[csf_pkg::BIT_ZERO];
    end else if (bus_wr_flags) begin
      zero_r <= REG_WDATA[csf_pkg::BIT_ZERO];
    end
  end

  // Nibble carry flag.
  always_ff @(posedge CLK) begin
    if (RST) begin
      nibble_r <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_NIBBLE];
    end else if (EXEC && upd_nibble) begin
      nibble_r <= alu_nibble;
    end else if (instr_wr_flags && !op_clear) begin
      nibble_r <= alu_result[csf_pkg::BIT_NIBBLE];
    end else if (bus_wr_flags) begin
      nibble_r <= REG_WDATA[csf_pkg::BIT_NIBBLE];
    end
  end

  // Carry flag.
  always_ff @(posedge CLK) begin
    if (RST) begin
      carry_r <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_CARRY];
    end else if (EXEC && upd_carry) begin
      carry_r <= alu_carry;
    end else if (instr_wr_flags && !op_clear) begin
      carry_r <= alu_result[csf_pkg::BIT_CARRY];
    end else if (bus_wr_flags) begin
      carry_r <= REG_WDATA[csf_pkg::BIT_CARRY];
    end
  end

  assign flags_view = {upper_r, timeout_r, sleep_r, zero_r, nibble_r,
                       carry_r};
  assign FLAGS      = flags_view;

  // Result of the last instruction, for the file write path.
  always_ff @(posedge CLK) begin
    if (RST) begin
      result_r       <= 8'h00;
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= EXEC && (OP != csf_pkg::OP_NONE)
                     && (OP != csf_pkg::OP_WDT_CLR)
                     && (OP != csf_pkg::OP_SLEEP);
      if (EXEC) begin
        result_r <= alu_result;
      end
    end
  end

  assign RESULT       = result_r;
  assign RESULT_VALID = result_valid_r;

  assign DATA_ADDR = {upper_r[csf_pkg::BIT_PAGE_LO - 5], DIRECT_OFS};

  // Interrupt events: time-out, sleep entry and watchdog clear.
  always_comb begin
    irq_set = 3'h0;
    irq_set[csf_pkg::IRQ_BIT_TMO]    = WDT_TIMEOUT;
    irq_set[csf_pkg::IRQ_BIT_SLEEP]  = op_sleep;
    irq_set[csf_pkg::IRQ_BIT_WDTCLR] = op_wdt_clr;
  end

  assign irq_clr = wr_irq_clear ? REG_WDATA[2:0] : 3'h0;

  // A new event in the cycle of its clear is kept: set wins.
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_status_r <= csf_pkg::IRQ_RESET;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_enable_r <= csf_pkg::IRQ_RESET;
    end else if (wr_irq_enable) begin
      irq_enable_r <= REG_WDATA[2:0];
    end
  end

  assign IRQ = |(irq_status_r & irq_enable_r);

  // Read data stand for one cycle after the strobe; unmapped reads give 0.
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_r <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        csf_pkg::OFS_FLAGS:      rdata_r <= flags_view;
        csf_pkg::OFS_IRQ_STATUS: rdata_r <= {5'h00, irq_status_r};
        csf_pkg::OFS_IRQ_ENABLE: rdata_r <= {5'h00, irq_enable_r};
        csf_pkg::OFS_RESULT:     rdata_r <= result_r;
        default:                 rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign REG_RDATA = rdata_r;

endmodule : csf_status_reg

// File: shared/csf_pkg.sv
package csf_pkg;

  // Data path and register port widths.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;

  // Register offsets on the register port.
  localparam logic [7:0] OFS_FLAGS      = 8'h83;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hA0;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'hA1;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'hA2;
  localparam logic [7:0] OFS_RESULT     = 8'hA3;

  // Field positions in processor_flags.
  localparam int BIT_INDIRECT_PAGE = 7;
  localparam int BIT_PAGE_HI       = 6;
  localparam int BIT_PAGE_LO       = 5;
  localparam int BIT_TIMEOUT       = 4;
  localparam int BIT_SLEEP         = 3;
  localparam int BIT_ZERO          = 2;
  localparam int BIT_NIBBLE        = 1;
  localparam int BIT_CARRY         = 0;

  // Power-up value: time-out and power-down flags set, the rest cleared.
  localparam logic [7:0] FLAGS_RESET = 8'h18;

  // Interrupt event bit positions and width.
  localparam int IRQ_W          = 3;
  localparam int IRQ_BIT_TMO    = 0;
  localparam int IRQ_BIT_SLEEP  = 1;
  localparam int IRQ_BIT_WDTCLR = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Direct addressing: bank size of 128 bytes, 7-bit offset in a bank.
  localparam int BANK_OFS_W = 7;

  // Operations presented by the instruction decoder.
  typedef enum logic [3:0] {
    OP_NONE,
    OP_MOVE_W,
    OP_MOVE_F,
    OP_CLEAR,
    OP_ADD_REG,
    OP_ADD_LIT,
    OP_SUB_REG,
    OP_SUB_LIT,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_ROT_R,
    OP_ROT_L,
    OP_WDT_CLR,
    OP_SLEEP
  } csf_op_t;

endpackage : csf_pkg

// File: rtl/csf_alu.sv
`timescale 1ns/1ns
module csf_alu (
  // Operation and operands
  input  wire csf_pkg::csf_op_t op,
  input  wire logic [7:0]       opnd_w,
  input  wire logic [7:0]       opnd_f,
  input  wire logic             carry_in,
  // Result and flags
  output logic [7:0]            result,
  output logic                  zero,
  output logic                  nibble,
  output logic                  carry,
  // Which flags the operation owns
  output logic                  upd_zero,
  output logic                  upd_nibble,
  output logic                  upd_carry
);

  logic [7:0] addend;
  logic       add_cin;
  logic [8:0] sum;
  logic [4:0] nib_sum;
  logic       is_add;
  logic       is_sub;

  assign is_add = (op == csf_pkg::OP_ADD_REG) || (op == csf_pkg::OP_ADD_LIT);
  assign is_sub = (op == csf_pkg::OP_SUB_REG) || (op == csf_pkg::OP_SUB_LIT);

  assign addend  = is_sub ? ~opnd_w : opnd_w;
  assign add_cin = is_sub;
  assign sum     = {1'b0, opnd_f} + {1'b0, addend} + {8'h00, add_cin};
  assign nib_sum = {1'b0, opnd_f[3:0]} + {1'b0, addend[3:0]}
                 + {4'h0, add_cin};

  always_comb begin
    result     = opnd_f;
    carry      = carry_in;
    upd_zero   = 1'b0;
    upd_nibble = 1'b0;
    upd_carry  = 1'b0;
    case (op)
      csf_pkg::OP_MOVE_W: result = opnd_w;
      csf_pkg::OP_MOVE_F: begin
        result   = opnd_f;
        upd_zero = 1'b1;
      end
      csf_pkg::OP_CLEAR: begin
        result   = 8'h00;
        upd_zero = 1'b1;
      end
      csf_pkg::OP_ADD_REG, csf_pkg::OP_ADD_LIT,
      csf_pkg::OP_SUB_REG, csf_pkg::OP_SUB_LIT: begin
        result     = sum[7:0];
        carry      = sum[8];
        upd_zero   = 1'b1;
        upd_nibble = 1'b1;
        upd_carry  = 1'b1;
      end
      csf_pkg::OP_AND: begin
        result   = opnd_f & opnd_w;
        upd_zero = 1'b1;
      end
      csf_pkg::OP_OR: begin
        result   = opnd_f | opnd_w;
        upd_zero = 1'b1;
      end
      csf_pkg::OP_XOR: begin
        result   = opnd_f ^ opnd_w;
        upd_zero = 1'b1;
      end
      csf_pkg::OP_ROT_R: begin
        result    = {carry_in, opnd_f[7:1]};
        carry     = opnd_f[0];
        upd_carry = 1'b1;
      end
      csf_pkg::OP_ROT_L: begin
        result    = {opnd_f[6:0], carry_in};
        carry     = opnd_f[7];
        upd_carry = 1'b1;
      end
      default: result = opnd_f;
    endcase
  end

  assign zero   = (result == 8'h00);
  assign nibble = nib_sum[4];

endmodule : csf_alu

// File: testbench/csf_status_reg_assertions.sv
`timescale 1ns/1ns
module csf_status_reg_chk (
  // Clock, reset and instruction side
  input wire logic             CLK,
  input wire logic             RST,
  input wire logic             EXEC,
  input wire csf_pkg::csf_op_t OP,
  input wire logic [7:0]       OPND_W,
  input wire logic [7:0]       OPND_F,
  input wire logic             DEST_IS_FLAGS,
  input wire logic             WDT_TIMEOUT,
  // Outputs and register port
  input wire logic [7:0]       RESULT,
  input wire logic [6:0]       DIRECT_OFS,
  input wire logic [7:0]       DATA_ADDR,
  input wire logic [7:0]       FLAGS,
  input wire logic             REG_RD,
  input wire logic [7:0]       REG_RDATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_timeout_clear: assert property (
    WDT_TIMEOUT |=> !FLAGS[4]) else $error("time-out flag kept");
  a_sleep_flags: assert property (
    EXEC && OP == csf_pkg::OP_SLEEP && !WDT_TIMEOUT
    |=> FLAGS[4:3] == 2'b10) else $error("sleep flags wrong");
  a_wdt_clear_flags: assert property (
    EXEC && OP == csf_pkg::OP_WDT_CLR && !WDT_TIMEOUT
    |=> FLAGS[4:3] == 2'b11) else $error("watchdog clear flags wrong");
  a_cause_hold: assert property (
    !WDT_TIMEOUT && !(EXEC && OP inside {csf_pkg::OP_SLEEP,
    csf_pkg::OP_WDT_CLR}) |=> $stable(FLAGS[4:3]))
    else $error("reset-cause flags changed");
  a_bank_addr: assert property (
    DATA_ADDR == {FLAGS[5], DIRECT_OFS}) else $error("bank address wrong");
  a_zero_flag: assert property (
    EXEC && OP inside {[csf_pkg::OP_MOVE_F:csf_pkg::OP_XOR]}
    |=> FLAGS[2] == (RESULT == 8'h00)) else $error("zero flag wrong");
  a_clear_flags: assert property (
    EXEC && OP == csf_pkg::OP_CLEAR && DEST_IS_FLAGS && !WDT_TIMEOUT
    |=> FLAGS == {3'h0, $past(FLAGS[4:3]), 1'b1, $past(FLAGS[1:0])})
    else $error("clear of flags wrong");
  a_add_carry: assert property (
    EXEC && OP inside {csf_pkg::OP_ADD_REG, csf_pkg::OP_ADD_LIT}
    |=> {FLAGS[0], RESULT} == {1'b0, $past(OPND_W)} + {1'b0, $past(OPND_F)})
    else $error("sum or carry wrong");
  a_add_nibble: assert property (
    EXEC && OP == csf_pkg::OP_ADD_LIT
    |=> FLAGS[1] == ($past(OPND_W[3:0]) + $past(OPND_F[3:0]) > 5'h0F))
    else $error("nibble carry wrong");
  a_sub_borrow: assert property (
    EXEC && OP == csf_pkg::OP_SUB_REG
    |=> FLAGS[0] == ($past(OPND_F) >= $past(OPND_W)))
    else $error("borrow flag wrong");
  a_rot_carry: assert property (
    EXEC && OP == csf_pkg::OP_ROT_L |=> FLAGS[0] == $past(OPND_F[7]))
    else $error("rotate carry wrong");
  a_rdata_idle: assert property (
    !REG_RD |=> REG_RDATA == 8'h00) else $error("read data not idle");
endmodule : csf_status_reg_chk

bind csf_status_reg csf_status_reg_chk u_chk (.CLK, .RST, .EXEC, .OP,
  .OPND_W, .OPND_F, .DEST_IS_FLAGS, .WDT_TIMEOUT, .RESULT, .DIRECT_OFS,
  .DATA_ADDR, .FLAGS, .REG_RD, .REG_RDATA);

// File: testbench/tb_csf_status_reg.sv
`timescale 1ns/1ns
module tb_csf_status_reg;
  logic             CLK = 1'b0;
  logic             RST = 1'b1;
  logic             EXEC = 1'b0;
  csf_pkg::csf_op_t OP = csf_pkg::OP_NONE;
  logic [7:0]       OPND_W = 8'h00;
  logic [7:0]       OPND_F = 8'h00;
  logic             DEST_IS_FLAGS = 1'b0;
  logic             WDT_TIMEOUT = 1'b0;
  logic [6:0]       DIRECT_OFS = 7'h00;
  logic [7:0]       REG_ADDR = 8'h00;
  logic [7:0]       REG_WDATA = 8'h00;
  logic             REG_WR = 1'b0;
  logic             REG_RD = 1'b0;
  logic [7:0]       RESULT, DATA_ADDR, FLAGS, REG_RDATA;
  logic             RESULT_VALID, IRQ;
  int               n_fail = 0;
  int               checks = 0;
  int               cyc = 0;
  logic [7:0]       q, ef, w, f;
  logic [10:0]      e;
  csf_pkg::csf_op_t o;
  csf_pkg::csf_op_t ops [10] = '{csf_pkg::OP_ADD_REG, csf_pkg::OP_ADD_LIT,
    csf_pkg::OP_SUB_REG, csf_pkg::OP_SUB_LIT, csf_pkg::OP_AND,
    csf_pkg::OP_OR, csf_pkg::OP_XOR, csf_pkg::OP_MOVE_F,
    csf_pkg::OP_ROT_R, csf_pkg::OP_ROT_L};
  // Boundary operands: zero sums, nibble carries and a borrow through zero.
  logic [7:0]       cw [4] = '{8'h08, 8'h01, 8'h05, 8'h01};
  logic [7:0]       cf [4] = '{8'hF8, 8'h0F, 8'h05, 8'h00};

  csf_status_reg dut (.CLK, .RST, .EXEC, .OP, .OPND_W, .OPND_F,
    .DEST_IS_FLAGS, .WDT_TIMEOUT, .RESULT, .RESULT_VALID, .DIRECT_OFS,
    .DATA_ADDR, .FLAGS, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .IRQ);

  always #10 CLK = ~CLK;

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(logic [7:0] g, logic [7:0] x);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic bus(logic wr, logic [7:0] a, logic [7:0] d);
    @(posedge CLK);
    REG_WR    <= wr;
    REG_RD    <= !wr;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    #1 q = REG_RDATA;
  endtask : bus

  task automatic run(csf_pkg::csf_op_t p, logic [7:0] a, logic [7:0] b,
                     logic d, logic t);
    @(posedge CLK);
    EXEC          <= 1'b1;
    OP            <= p;
    OPND_W        <= a;
    OPND_F        <= b;
    DIRECT_OFS    <= b[6:0];
    DEST_IS_FLAGS <= d;
    WDT_TIMEOUT   <= t;
    @(posedge CLK);
    EXEC          <= 1'b0;
    DEST_IS_FLAGS <= 1'b0;
    WDT_TIMEOUT   <= 1'b0;
    #1;
  endtask : run

  function automatic logic [10:0] alu(csf_pkg::csf_op_t p, logic [7:0] a,
                                      logic [7:0] b, logic ci);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] r;
    s = {1'b0, b} + {1'b0, a};
    n = {1'b0, b[3:0]} + {1'b0, a[3:0]};
    if (p == csf_pkg::OP_SUB_REG || p == csf_pkg::OP_SUB_LIT) begin
      s = {1'b0, b} + {1'b0, ~a} + 9'h001;
      n = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
    end
    r = s[7:0];
    case (p)
      csf_pkg::OP_AND:    r = b & a;
      csf_pkg::OP_OR:     r = b | a;
      csf_pkg::OP_XOR:    r = b ^ a;
      csf_pkg::OP_MOVE_F: r = b;
      csf_pkg::OP_ROT_R: begin
        r    = {ci, b[7:1]};
        s[8] = b[0];
      end
      csf_pkg::OP_ROT_L: begin
        r    = {b[6:0], ci};
        s[8] = b[7];
      end
      default: ;
    endcase
    return {r == 8'h00, n[4], s[8], r};
  endfunction : alu

  initial begin
    q = 8'($urandom(32'hF620));
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    #1;
    chk(FLAGS, 8'h18);
    bus(1'b0, 8'h83, 8'h00);
    chk(q, 8'h18);
    bus(1'b0, 8'h10, 8'h00);
    chk(q, 8'h00);
    bus(1'b1, 8'h83, 8'h00);
    chk(FLAGS, 8'h18);
    bus(1'b1, 8'h83, 8'hE7);
    chk(FLAGS, 8'hFF);
    bus(1'b1, 8'hA1, 8'h07);
    run(csf_pkg::OP_CLEAR, 8'h12, 8'h35, 1'b1, 1'b0);
    chk(FLAGS, 8'h1F);
    chk(DATA_ADDR, 8'h35);
    run(csf_pkg::OP_ADD_REG, 8'h08, 8'h08, 1'b1, 1'b0);
    chk(FLAGS, 8'h1A);
    chk(RESULT, 8'h10);
    run(csf_pkg::OP_MOVE_W, 8'hA7, 8'h35, 1'b1, 1'b0);
    chk(FLAGS, 8'hBF);
    chk(DATA_ADDR, 8'hB5);
    bus(1'b1, 8'h83, 8'h00);
    run(csf_pkg::OP_SLEEP, 8'h00, 8'h00, 1'b0, 1'b0);
    chk(FLAGS, 8'h10);
    chk({7'h00, RESULT_VALID}, 8'h00);
    bus(1'b1, 8'h83, 8'h08);
    chk(FLAGS, 8'h10);
    run(csf_pkg::OP_WDT_CLR, 8'h00, 8'h00, 1'b0, 1'b1);
    chk(FLAGS, 8'h08);
    bus(1'b0, 8'hA0, 8'h00);
    chk(q, 8'h07);
    chk({7'h00, IRQ}, 8'h01);
    bus(1'b1, 8'hA1, 8'h00);
    chk({7'h00, IRQ}, 8'h00);
    bus(1'b1, 8'hA1, 8'h05);
    chk({7'h00, IRQ}, 8'h01);
    bus(1'b1, 8'hA2, 8'h07);
    bus(1'b0, 8'hA0, 8'h00);
    chk(q, 8'h00);
    chk({7'h00, IRQ}, 8'h00);
    ef = 8'h08;
    for (int i = 0; i < 300; i++) begin
      o = ops[$urandom_range(9)];
      w = 8'($urandom);
      f = 8'($urandom);
      if (i < 4) begin
        o = ops[i];
        w = cw[i];
        f = cf[i];
      end
      e = alu(o, w, f, ef[0]);
      run(o, w, f, 1'b0, 1'b0);
      if (o == csf_pkg::OP_ROT_R || o == csf_pkg::OP_ROT_L)
        ef[0] = e[8];
      else if (o >= csf_pkg::OP_AND || o == csf_pkg::OP_MOVE_F)
        ef[2] = e[10];
      else
        ef[2:0] = e[10:8];
      chk(RESULT, e[7:0]);
      chk(FLAGS, ef);
      chk({7'h00, RESULT_VALID}, 8'h01);
      chk(DATA_ADDR, {ef[5], f[6:0]});
    end
    finish_test();
  end
endmodule : tb_csf_status_reg
